// file: design/erf_pkg.sv
// constants, field layouts and carriers of the receive filter and buffer
// assumes a 25 MHz core clock and an mii receive clock from the phy
package erf_pkg;

  localparam logic [7:0]  OFS_MAC_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_STATION_HIGH = 8'h04;
  localparam logic [7:0]  OFS_STATION_LOW  = 8'h08;
  localparam logic [7:0]  OFS_HASH_HIGH    = 8'h0C;
  localparam logic [7:0]  OFS_HASH_LOW     = 8'h10;
  localparam logic [7:0]  OFS_TAG_ONE      = 8'h20;
  localparam logic [7:0]  OFS_TAG_TWO      = 8'h24;
  localparam logic [7:0]  SFR_BUFFER_SPLIT = 8'hE5;
  localparam logic [23:0] MEM_BASE         = 24'hFFE000;
  localparam int          MEM_BYTES        = 8192;

  localparam logic [31:0] MAC_CONTROL_RST  = 32'h00000008;
  localparam logic [4:0]  BUFFER_SPLIT_RST = 5'h00;
  localparam int          HASH_PERMIT_BIT  = 0;
  localparam int          HASH_ONLY_BIT    = 1;
  localparam int          INVERSE_BIT      = 2;
  localparam int          PROMISC_BIT      = 3;
  localparam int          PASS_MCAST_BIT   = 4;
  localparam int          BCAST_DIS_BIT    = 5;
  localparam int          HALF_DUPLEX_BIT  = 6;

  localparam logic [3:0]  SFD_HIGH_NIBBLE  = 4'hD;
  localparam logic [13:0] MAX_FRAME        = 14'h05EE;
  localparam logic [13:0] MIN_FRAME        = 14'h0040;
  localparam logic [13:0] TAG_ONE_EXTRA    = 14'h0004;
  localparam logic [13:0] TAG_TWO_EXTRA    = 14'h0014;
  localparam logic [13:0] TPID_BYTE        = 14'h000C;
  localparam logic [13:0] DA_LAST_BYTE     = 14'h0005;
  localparam logic [15:0] LEN_TYPE_LIMIT   = 16'h05DC;
  localparam logic [31:0] CRC_POLY         = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT         = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE      = 32'hC704DD7B;
  localparam logic [7:0]  FIRST_DATA_BYTE  = 8'h04;

  typedef struct packed {
    logic        missed;
    logic        pkt_pass;
    logic        filter_fail_flag;
    logic        bcast_flag;
    logic        mcast_flag;
    logic        ctrl_unsup;
    logic        ctrl_frame;
    logic        len_error;
    logic        tag_two_seen;
    logic        tag_one_seen;
    logic        crc_error;
    logic        dribble;
    logic        mii_error;
    logic        is_type;
    logic        coll_seen;
    logic        too_long;
    logic        runt;
    logic        wdog;
    logic [13:0] frame_len;
  } erf_rx_stat_s;

  typedef struct packed {
    logic        retry;
    logic [15:0] rsvd;
    logic        heartbeat_fail;
    logic [3:0]  collision_tally;
    logic        late_collision_seen;
    logic        deferred;
    logic        underrun;
    logic        too_many_collisions;
    logic        late_collision_abort;
    logic        excess_deferral;
    logic        carrier_lost;
    logic        no_carrier;
    logic        jabber;
    logic        aborted;
  } erf_tx_stat_s;

  typedef struct packed {
    logic [4:0]   page;
    erf_tx_stat_s stat;
  } erf_tx_rep_s;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_BODY, ST_DONE, ST_SKIP
  } erf_rx_st_e;

  // bit-serial crc, byte fed lsb first as it arrives on the wire
  function automatic logic [31:0] erf_crc8(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[31] ^ d[i]) ? ({r[30:0], 1'b0} ^ CRC_POLY) : {r[30:0], 1'b0};
    end
    return r;
  endfunction : erf_crc8

endpackage : erf_pkg

// file: design/erf_rx_filter.sv
// receive address filter, tag detection, packet memory and status words
// assumes csr, sfr and memory ports come from cpu logic on the core clock;
// mii receive pins are asynchronous and are synchronised here
//
// How it works
// - first received da bit 0 means unicast, 1 means multicast
// - all-ones da is broadcast, accepted unless broadcast disable is set without promiscuous pass-all
// - perfect passes da equal to station address, inverse passes others
// - perfect and inverse compare only unicast frames
// - five mode bits decode into unicast and multicast criteria
// - promiscuous without inverse passes all; mode bits reset to 01000b
// - hash runs six da bytes through crc-32, top six bits index
// - index msb picks high or low table, low five bits pick bit
// - filter result, broadcast and multicast go into receive status
// - bytes 13 and 14 are compared with both tag identifiers
// - non-zero match on tag one: single tag, limit plus four
// - non-zero match on tag two: double tag, limit plus twenty
// - 8kB memory shared by cpu data moves and buffer control unit
// - memory is 32 pages of 64 words; packets span pages
// - lowest n pages receive, the rest transmit
// - split resets to zero pages receive; 31 leaves page 31 transmit
// - any change of split flushes receive buffer state
// - status word goes to word 0 of the packet's first page
// - transmit bit 31 set when collision needs a resend
// - half duplex records collision tally in four bits
// - late collision seen always set with late collision abort
// - filter fail bit set when da failed the filter
`timescale 1ns/1ns
module erf_rx_filter
  import erf_pkg::*;
#(
  parameter logic [13:0] MAX_LEN = MAX_FRAME
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         rx_clk,
  input  wire logic         rx_dv,
  input  wire logic         rx_er,
  input  wire logic [3:0]   rxd,
  input  wire logic         csr_wr,
  input  wire logic         csr_rd,
  input  wire logic [7:0]   csr_addr,
  input  wire logic [31:0]  csr_wdata,
  output logic      [31:0]  csr_rdata,
  input  wire logic         sfr_wr,
  input  wire logic [7:0]   sfr_addr,
  input  wire logic [7:0]   sfr_wdata,
  output logic      [7:0]   sfr_rdata,
  input  wire logic         xdm_en,
  input  wire logic         xdm_wr,
  input  wire logic [23:0]  xdm_addr,
  input  wire logic [7:0]   xdm_wdata,
  output logic      [7:0]   xdm_rdata,
  input  wire logic         tx_rep_valid,
  input  wire erf_tx_rep_s  tx_rep,
  output erf_rx_stat_s      rx_status,
  output logic              rx_done
);

  // limit plus the double-tag extension must still fit the length field
  if (MAX_LEN > 14'h3FEB) begin : g_len_chk
    $error("MAX_LEN out of range");
  end

  logic [31:0]  mac_control_r;
  logic [31:0]  station_high_r;
  logic [31:0]  station_low_r;
  logic [31:0]  hash_high_r;
  logic [31:0]  hash_low_r;
  logic [31:0]  tag_one_r;
  logic [31:0]  tag_two_r;
  logic [4:0]   split_r;
  logic         flush_r;
  logic [6:0]   pin_s1_r;
  logic [6:0]   pin_s2_r;
  logic         clk_d_r;
  erf_rx_st_e   st_r;
  logic [3:0]   nib_lo_r;
  logic         nib_hi_r;
  logic [13:0]  cnt_r;
  logic [31:0]  crc_r;
  logic [5:0]   hash_idx_r;
  logic [47:0]  da_r;
  logic [7:0]   tpid_hi_r;
  logic [15:0]  tpid_r;
  logic         er_seen_r;
  logic [4:0]   start_pg_r;
  logic [12:0]  ptr_r;
  logic [7:0]   mem_r [MEM_BYTES];
  logic [31:0]  csr_rdata_r;
  logic [7:0]   sfr_rdata_r;
  logic [7:0]   xdm_rdata_r;
  erf_rx_stat_s rx_status_r;
  logic         rx_done_r;

  assign csr_rdata = csr_rdata_r;
  assign sfr_rdata = sfr_rdata_r;
  assign xdm_rdata = xdm_rdata_r;
  assign rx_status = rx_status_r;
  assign rx_done   = rx_done_r;

  // pins: two stages before any logic, edges found on the second stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      clk_d_r  <= 1'b0;
    end else begin
      pin_s1_r <= {rx_clk, rx_dv, rx_er, rxd};
      pin_s2_r <= pin_s1_r;
      clk_d_r  <= pin_s2_r[6];
    end
  end

  logic       dv_s;
  logic       er_s;
  logic [3:0] rxd_s;
  logic       link_fall;
  assign dv_s  = pin_s2_r[5];
  assign er_s  = pin_s2_r[4];
  assign rxd_s = pin_s2_r[3:0];
  // sample on the falling edge, mid-bit, far from the phy's launch edge
  assign link_fall = clk_d_r & ~pin_s2_r[6];

  logic cpu_csr_hit_wr;
  assign cpu_csr_hit_wr = csr_wr;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mac_control_r  <= MAC_CONTROL_RST;
      station_high_r <= 32'h00000000;
      station_low_r  <= 32'h00000000;
      hash_high_r    <= 32'h00000000;
      hash_low_r     <= 32'h00000000;
      tag_one_r      <= 32'h00000000;
      tag_two_r      <= 32'h00000000;
    end else if (cpu_csr_hit_wr) begin
      case (csr_addr)
        OFS_MAC_CONTROL:  mac_control_r  <= csr_wdata;
        OFS_STATION_HIGH: station_high_r <= csr_wdata;
        OFS_STATION_LOW:  station_low_r  <= csr_wdata;
        OFS_HASH_HIGH:    hash_high_r    <= csr_wdata;
        OFS_HASH_LOW:     hash_low_r     <= csr_wdata;
        OFS_TAG_ONE:      tag_one_r      <= csr_wdata;
        OFS_TAG_TWO:      tag_two_r      <= csr_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      csr_rdata_r <= 32'h00000000;
    end else if (csr_rd) begin
      case (csr_addr)
        OFS_MAC_CONTROL:  csr_rdata_r <= mac_control_r;
        OFS_STATION_HIGH: csr_rdata_r <= station_high_r;
        OFS_STATION_LOW:  csr_rdata_r <= station_low_r;
        OFS_HASH_HIGH:    csr_rdata_r <= hash_high_r;
        OFS_HASH_LOW:     csr_rdata_r <= hash_low_r;
        OFS_TAG_ONE:      csr_rdata_r <= tag_one_r;
        OFS_TAG_TWO:      csr_rdata_r <= tag_two_r;
        default:          csr_rdata_r <= 32'h00000000;
      endcase
    end
  end

  logic split_wr;
  assign split_wr = sfr_wr && (sfr_addr == SFR_BUFFER_SPLIT);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      split_r     <= BUFFER_SPLIT_RST;
      flush_r     <= 1'b0;
      sfr_rdata_r <= 8'h00;
    end else begin
      flush_r <= split_wr && (sfr_wdata[4:0] != split_r);
      if (split_wr) begin
        split_r <= sfr_wdata[4:0];
      end
      sfr_rdata_r <= (sfr_addr == SFR_BUFFER_SPLIT) ? {3'b000, split_r} : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (dv_s) begin
            st_r <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (!dv_s) begin
            st_r <= ST_IDLE;
          end else if (link_fall && rxd_s == SFD_HIGH_NIBBLE) begin
            st_r <= ST_BODY;
          end
        end
        ST_BODY: begin
          if (flush_r) begin
            st_r <= ST_SKIP;
          end else if (!dv_s) begin
            st_r <= ST_DONE;
          end
        end
        ST_DONE: st_r <= ST_IDLE;
        ST_SKIP: begin
          if (!dv_s) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  logic        frame_start;
  logic        byte_stb;
  logic [7:0]  byte_c;
  logic [31:0] crc_nxt;
  assign frame_start = (st_r == ST_PRE) && dv_s && link_fall && (rxd_s == SFD_HIGH_NIBBLE);
  assign byte_stb    = (st_r == ST_BODY) && dv_s && link_fall && nib_hi_r;
  assign byte_c      = {rxd_s, nib_lo_r};
  assign crc_nxt     = erf_crc8(crc_r, byte_c);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nib_lo_r   <= 4'h0;
      nib_hi_r   <= 1'b0;
      cnt_r      <= 14'h0000;
      crc_r      <= CRC_INIT;
      hash_idx_r <= 6'h00;
      da_r       <= 48'h000000000000;
      tpid_hi_r  <= 8'h00;
      tpid_r     <= 16'h0000;
      er_seen_r  <= 1'b0;
    end else if (frame_start) begin
      nib_hi_r  <= 1'b0;
      cnt_r     <= 14'h0000;
      crc_r     <= CRC_INIT;
      tpid_r    <= 16'h0000;
      er_seen_r <= 1'b0;
    end else if (st_r == ST_BODY && dv_s && link_fall) begin
      er_seen_r <= er_seen_r | er_s;
      nib_hi_r  <= ~nib_hi_r;
      if (!nib_hi_r) begin
        nib_lo_r <= rxd_s;
      end else begin
        crc_r <= crc_nxt;
        if (cnt_r != 14'h3FFF) begin
          cnt_r <= cnt_r + 14'h0001;
        end
        if (cnt_r <= DA_LAST_BYTE) begin
          da_r <= {da_r[39:0], byte_c};
        end
        if (cnt_r == DA_LAST_BYTE) begin
          hash_idx_r <= crc_nxt[31:26];
        end
        if (cnt_r == TPID_BYTE) begin
          tpid_hi_r <= byte_c;
        end
        if (cnt_r == TPID_BYTE + 14'h0001) begin
          tpid_r <= {tpid_hi_r, byte_c};
        end
      end
    end
  end

  logic [47:0] station;
  logic        is_mcast;
  logic        is_bcast;
  logic        uc_match;
  logic        hash_hit;
  logic        pass_c;
  logic        tag_one_hit;
  logic        tag_two_hit;
  logic [13:0] len_limit;
  assign station  = {station_high_r[15:0], station_low_r};
  assign is_mcast = da_r[40];
  assign is_bcast = is_mcast && (da_r == 48'hFFFFFFFFFFFF);
  assign uc_match = (da_r == station);
  assign hash_hit = hash_idx_r[5] ? hash_high_r[hash_idx_r[4:0]]
                                  : hash_low_r[hash_idx_r[4:0]];
  assign tag_one_hit = (tpid_r != 16'h0000) && (tpid_r == tag_one_r[15:0]);
  assign tag_two_hit = (tpid_r != 16'h0000) && (tpid_r == tag_two_r[15:0]);
  assign len_limit = MAX_LEN + (tag_two_hit ? TAG_TWO_EXTRA
                              : (tag_one_hit ? TAG_ONE_EXTRA : 14'h0000));

  // table combinations come out exactly; others fall to the nearest meaning
  always_comb begin
    pass_c = 1'b0;
    if (mac_control_r[PROMISC_BIT] && !mac_control_r[INVERSE_BIT]) begin
      pass_c = 1'b1;
    end else if (is_bcast) begin
      pass_c = !mac_control_r[BCAST_DIS_BIT];
    end else if (is_mcast) begin
      pass_c = mac_control_r[PASS_MCAST_BIT] ||
               (mac_control_r[HASH_PERMIT_BIT] && hash_hit);
    end else if (mac_control_r[HASH_ONLY_BIT]) begin
      pass_c = hash_hit;
    end else if (mac_control_r[INVERSE_BIT]) begin
      pass_c = !uc_match;
    end else begin
      pass_c = uc_match;
    end
  end

  erf_rx_stat_s rx_word;
  always_comb begin
    rx_word                  = '0;
    rx_word.pkt_pass         = pass_c;
    rx_word.filter_fail_flag = !pass_c;
    rx_word.bcast_flag       = is_bcast;
    rx_word.mcast_flag       = is_mcast;
    rx_word.tag_two_seen     = tag_two_hit;
    rx_word.tag_one_seen     = tag_one_hit;
    rx_word.crc_error        = (crc_r != CRC_RESIDUE) || er_seen_r;
    rx_word.dribble          = nib_hi_r;
    rx_word.mii_error        = er_seen_r;
    rx_word.is_type          = tpid_r > LEN_TYPE_LIMIT;
    rx_word.too_long         = cnt_r > len_limit;
    rx_word.runt             = cnt_r < MIN_FRAME;
    rx_word.missed           = (split_r == 5'h00);
    rx_word.frame_len        = cnt_r;
  end

  logic        store_en;
  logic [12:0] region_end;
  logic [12:0] ptr_inc;
  logic [5:0]  next_pg;
  assign store_en   = (split_r != 5'h00);
  assign region_end = {split_r, 8'h00};
  assign ptr_inc    = ptr_r + 13'h0001;
  assign next_pg    = {1'b0, ptr_r[12:8]} + {5'h00, (ptr_r[7:0] != 8'h00)};

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      start_pg_r <= 5'h00;
      ptr_r      <= 13'h0000;
    end else if (flush_r) begin
      start_pg_r <= 5'h00;
      ptr_r      <= 13'h0000;
    end else if (frame_start) begin
      ptr_r <= {start_pg_r, FIRST_DATA_BYTE};
    end else if (byte_stb && store_en) begin
      ptr_r <= (ptr_inc == region_end) ? 13'h0000 : ptr_inc;
    end else if (st_r == ST_DONE && store_en) begin
      start_pg_r <= (next_pg >= {1'b0, split_r}) ? 5'h00 : next_pg[4:0];
    end
  end

  erf_tx_stat_s tx_word;
  always_comb begin
    tx_word = tx_rep.stat;
    tx_word.rsvd = 16'h0000;
    if (!mac_control_r[HALF_DUPLEX_BIT]) begin
      tx_word.collision_tally = 4'h0;
    end
    tx_word.late_collision_seen = tx_rep.stat.late_collision_seen ||
                                  tx_rep.stat.late_collision_abort;
  end

  logic cpu_mem_hit;
  assign cpu_mem_hit = xdm_en && (xdm_addr[23:13] == MEM_BASE[23:13]);

  // no reset on storage; a same-address clash lets hardware writes win
  always_ff @(posedge clock) begin
    if (cpu_mem_hit && xdm_wr) begin
      mem_r[xdm_addr[12:0]] <= xdm_wdata;
    end
    if (byte_stb && store_en) begin
      mem_r[ptr_r] <= byte_c;
    end
    if (st_r == ST_DONE && store_en) begin
      for (int k = 0; k < 4; k++) begin
        mem_r[{start_pg_r, 8'(k)}] <= rx_word[8*k +: 8];
      end
    end
    if (tx_rep_valid) begin
      for (int k = 0; k < 4; k++) begin
        mem_r[{tx_rep.page, 8'(k)}] <= tx_word[8*k +: 8];
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xdm_rdata_r <= 8'h00;
    end else if (xdm_en && !xdm_wr) begin
      xdm_rdata_r <= cpu_mem_hit ? mem_r[xdm_addr[12:0]] : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_status_r <= '0;
      rx_done_r   <= 1'b0;
    end else begin
      rx_done_r <= (st_r == ST_DONE);
      if (st_r == ST_DONE) begin
        rx_status_r <= rx_word;
      end
    end
  end

endmodule : erf_rx_filter

// file: sim/erf_rx_filter_asserts.sv
// port checker for erf_rx_filter: status pulse, csr, sfr and memory answers
// assumes it is bound onto erf_rx_filter and shares its core clock
`timescale 1ns/1ns
module erf_rx_filter_asserts
  import erf_pkg::*;
#(
  parameter logic [13:0] MAX_LEN = MAX_FRAME
) (
  input wire logic         clock,
  input wire logic         rst,
  input wire logic         csr_rd,
  input wire logic [7:0]   csr_addr,
  input wire logic [31:0]  csr_rdata,
  input wire logic         sfr_wr,
  input wire logic [7:0]   sfr_addr,
  input wire logic [7:0]   sfr_wdata,
  input wire logic [7:0]   sfr_rdata,
  input wire logic         xdm_en,
  input wire logic         xdm_wr,
  input wire logic [23:0]  xdm_addr,
  input wire logic [7:0]   xdm_rdata,
  input wire erf_rx_stat_s rx_status,
  input wire logic         rx_done
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_done_pulse: assert property (rx_done |=> !rx_done)
    else $error("rx_done longer than one cycle");
  a_status_hold: assert property ($changed(rx_status) |-> rx_done)
    else $error("rx_status moved without rx_done");
  a_bcast_mcast: assert property (rx_done && rx_status.bcast_flag
    |-> rx_status.mcast_flag)
    else $error("broadcast frame not flagged multicast");
  a_plain_long: assert property (rx_done && rx_status.frame_len > MAX_LEN
    && !rx_status.tag_one_seen && !rx_status.tag_two_seen |-> rx_status.too_long)
    else $error("untagged frame over limit not flagged long");
  a_tag_two_len: assert property (rx_done && rx_status.tag_two_seen
    && rx_status.frame_len <= MAX_LEN + TAG_TWO_EXTRA |-> !rx_status.too_long)
    else $error("double tagged frame flagged long");
  a_csr_unmap: assert property (csr_rd && csr_addr[7:6] != 2'h0
    |=> csr_rdata == 32'h0)
    else $error("unmapped csr read not zero");
  a_csr_hold: assert property (!csr_rd |=> $stable(csr_rdata))
    else $error("csr read data moved without a read");
  a_mem_range: assert property (xdm_en && !xdm_wr
    && xdm_addr < MEM_BASE |=> xdm_rdata == 8'h00)
    else $error("read outside packet memory not zero");
  a_split_read: assert property (sfr_wr && sfr_addr == SFR_BUFFER_SPLIT ##1
    sfr_addr == SFR_BUFFER_SPLIT && !sfr_wr |=> sfr_rdata == ($past(sfr_wdata, 2) & 8'h1F))
    else $error("split readback wrong");
  a_sfr_other: assert property (sfr_addr != SFR_BUFFER_SPLIT |=> sfr_rdata == 8'h00)
    else $error("other sfr address not zero");

  c_bcast: cover property (rx_done && rx_status.bcast_flag);
  c_tag_two: cover property (rx_done && rx_status.tag_two_seen);
  c_missed: cover property (rx_done && rx_status.missed);
endmodule : erf_rx_filter_asserts

bind erf_rx_filter erf_rx_filter_asserts #(.MAX_LEN(MAX_LEN)) chk_u (
  .clock(clock), .rst(rst), .csr_rd(csr_rd), .csr_addr(csr_addr), .csr_rdata(csr_rdata),
  .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .xdm_en(xdm_en), .xdm_wr(xdm_wr), .xdm_addr(xdm_addr), .xdm_rdata(xdm_rdata),
  .rx_status(rx_status), .rx_done(rx_done)
);

// file: sim/erf_phy_model.sv
// phy side of the mii receive path: clock, data valid and nibbles
// assumes the bench calls send; the receive clock stands still between frames
`timescale 1ns/1ns
module erf_phy_model (
  output logic       rx_clk,
  output logic       rx_dv,
  output logic       rx_er,
  output logic [3:0] rxd
);
  initial begin
    rx_clk = 1'b0;
    rx_dv  = 1'b0;
    rx_er  = 1'b0;
    rxd    = 4'h0;
  end

  // odd offset keeps link edges off the core clock edges
  task automatic send(input logic [7:0] fb [64], input int n);
    #13;
    for (int i = 0; i < 2 * n; i++) begin
      rx_clk = 1'b1;
      rx_dv  = 1'b1;
      rxd    = i[0] ? fb[i / 2][7:4] : fb[i / 2][3:0];
      #160 rx_clk = 1'b0;
      #160;
    end
    rx_clk = 1'b1;
    rx_dv  = 1'b0;
    rxd    = ~rxd;  // released bus shows no stale nibble
    #160 rx_clk = 1'b0;
  endtask : send
endmodule : erf_phy_model

// file: sim/erf_rx_filter_tb_top.sv
// self-checking bench for erf_rx_filter: csr, sfr, memory, mii and tx reports
// assumes erf_phy_model on the mii pins and the bound port checker
`timescale 1ns/1ns
module erf_rx_filter_tb_top
  import erf_pkg::*;
;
  localparam logic [13:0] MAXL = 14'h0014;
  localparam logic [47:0] ME = 48'h020000000001;
  localparam logic [47:0] OT = 48'h020000000002;
  localparam logic [47:0] MC = 48'h01005E000001;
  localparam logic [47:0] BC = 48'hFFFFFFFFFFFF;
  logic clock = 1'b0, rst = 1'b1, rx_clk, rx_dv, rx_er, rx_done;
  logic [3:0] rxd;
  logic csr_wr = 1'b0, csr_rd = 1'b0, sfr_wr = 1'b0, xdm_en = 1'b0, xdm_wr = 1'b0;
  logic [7:0] csr_addr = 8'h00, sfr_addr = 8'h00, sfr_wdata = 8'h00, xdm_wdata = 8'h00;
  logic [31:0] csr_wdata = 32'h0, csr_rdata;
  logic [7:0] sfr_rdata, xdm_rdata;
  logic [23:0] xdm_addr = 24'h0;
  logic tx_rep_valid = 1'b0;
  erf_tx_rep_s tx_rep = '0;
  erf_rx_stat_s rx_status;
  logic [4:0] split = 5'h0;
  logic [15:0] tag1 = 16'h0, tag2 = 16'h0;
  int err_count = 0, check_count = 0, pg = 0;

  always #20 clock = ~clock;

  erf_phy_model phy_u (.rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));
  erf_rx_filter #(.MAX_LEN(MAXL)) dut_u (
    .clock(clock), .rst(rst), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
    .csr_wr(csr_wr), .csr_rd(csr_rd), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
    .csr_rdata(csr_rdata), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .xdm_en(xdm_en), .xdm_wr(xdm_wr), .xdm_addr(xdm_addr),
    .xdm_wdata(xdm_wdata), .xdm_rdata(xdm_rdata), .tx_rep_valid(tx_rep_valid),
    .tx_rep(tx_rep), .rx_status(rx_status), .rx_done(rx_done));

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic csr_w(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    csr_wr    <= 1'b1;
    csr_addr  <= a;
    csr_wdata <= d;
    @(posedge clock);
    csr_wr <= 1'b0;
  endtask : csr_w

  task automatic csr_r(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    csr_rd   <= 1'b1;
    csr_addr <= a;
    @(posedge clock);
    csr_rd <= 1'b0;
    #1 d = csr_rdata;
  endtask : csr_r

  task automatic mem(input logic w, input logic [23:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clock);
    xdm_en    <= 1'b1;
    xdm_wr    <= w;
    xdm_addr  <= a;
    xdm_wdata <= wd;
    @(posedge clock);
    xdm_en <= 1'b0;
    #1 rd = xdm_rdata;
  endtask : mem

  task automatic word(input logic [23:0] a, output logic [31:0] w);
    logic [7:0] b;
    for (int i = 0; i < 4; i++) begin
      mem(1'b0, a + 24'(i), 8'h00, b);
      w[8 * i +: 8] = b;
    end
  endtask : word

  task automatic split_set(input logic [7:0] d);
    @(posedge clock);
    sfr_wr    <= 1'b1;
    sfr_addr  <= SFR_BUFFER_SPLIT;
    sfr_wdata <= d;
    @(posedge clock);
    sfr_wr <= 1'b0;
    split = d[4:0];
    pg = 0;
    @(posedge clock);
    #1 check(sfr_rdata, {3'h0, d[4:0]});
  endtask : split_set

  function automatic logic [5:0] hidx(input logic [47:0] da);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 48; i++) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ da[40 - 8 * (i / 8) + i % 8]) ? CRC_POLY : 32'h0);
    end
    return c[31:26];
  endfunction : hidx

  task automatic rxf(input logic [47:0] da, input logic [15:0] ty, input int np, input logic ff);
    logic [7:0] fb [64];
    logic [7:0] b;
    logic [31:0] w;
    logic [13:0] len;
    logic t1, t2;
    int k;
    for (int i = 0; i < 64; i++) fb[i] = (i < 7) ? 8'h55 : 8'hA0 + 8'(i);
    fb[7] = 8'hD5;
    for (int i = 0; i < 6; i++) fb[8 + i] = da[47 - 8 * i -: 8];
    fb[20] = ty[15:8];
    fb[21] = ty[7:0];
    len = 14'(14 + np);
    t1 = tag1 != 16'h0 && ty == tag1;
    t2 = tag2 != 16'h0 && ty == tag2;
    fork
      phy_u.send(fb, 22 + np);
      for (k = 0; k < 2000 && rx_done !== 1'b1; k++) begin
        @(posedge clock);
        #1;
      end
    join
    check(rx_done, 1'b1);
    check(rx_status.missed, split == 5'h0);
    check(rx_status.filter_fail_flag, ff);
    check(rx_status.pkt_pass, !ff);
    check(rx_status.bcast_flag, &da);
    check(rx_status.mcast_flag, da[40]);
    check(rx_status.tag_one_seen, t1);
    check(rx_status.tag_two_seen, t2);
    check(rx_status.too_long, len > MAXL + (t2 ? 14'h14 : t1 ? 14'h04 : 14'h00));
    check(rx_status.frame_len, len);
    if (split != 5'h0) begin
      word(MEM_BASE + 24'(pg * 256), w);
      check(w, rx_status);
      mem(1'b0, MEM_BASE + 24'(pg * 256 + 4), 8'h00, b);
      check(b, da[47:40]);
      pg = (pg + 1) % split;
    end
  endtask : rxf

  task automatic flt(input logic [5:0] md, input logic [47:0] da, input logic hs, input logic ff);
    logic [5:0] ix;
    logic [31:0] hv, lv;
    ix = hidx(da);
    hv = ix[5] ? 32'h1 << ix[4:0] : 32'h0;
    lv = ix[5] ? 32'h0 : 32'h1 << ix[4:0];
    csr_w(OFS_HASH_HIGH, hs ? hv : ~hv);
    csr_w(OFS_HASH_LOW, hs ? lv : ~lv);
    csr_w(OFS_MAC_CONTROL, {26'h0, md});
    rxf(da, 16'h0800, 2, ff);
  endtask : flt

  task automatic txr(input logic hd);
    erf_tx_stat_s s, r;
    logic [31:0] w;
    s = '0;
    s.retry = 1'b1;
    s.rsvd = 16'hFFFF;
    s.collision_tally = 4'h5;
    s.late_collision_abort = 1'b1;
    csr_w(OFS_MAC_CONTROL, {25'h0, hd, 6'h08});
    @(posedge clock);
    tx_rep_valid <= 1'b1;
    tx_rep       <= {5'h14, s};
    @(posedge clock);
    tx_rep_valid <= 1'b0;
    word(MEM_BASE + 24'h1400, w);
    r = w;
    check(r.retry, 1'b1);
    check(r.rsvd, 16'h0);
    check(r.collision_tally, hd ? 4'h5 : 4'h0);
    check(r.late_collision_seen, 1'b1);
  endtask : txr

  initial begin
    #1_000_000;
    err_count++;
    final_report();
  end

  initial begin
    logic [31:0] v;
    logic [7:0] b;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    csr_r(OFS_MAC_CONTROL, v);
    check(v, 32'h00000008);
    csr_r(8'h40, v);
    check(v, 32'h0);
    sfr_addr <= SFR_BUFFER_SPLIT;
    repeat (2) @(posedge clock);
    #1 check(sfr_rdata, 8'h00);
    csr_w(OFS_STATION_HIGH, 32'h00000200);
    csr_w(OFS_STATION_LOW, 32'h00000001);
    csr_r(OFS_STATION_HIGH, v);
    check(v, 32'h00000200);
    rxf(ME, 16'h0800, 2, 1'b0);
    split_set(8'hE4);
    $display("test reset done");
    flt(6'h00, ME, 1'b0, 1'b0);
    flt(6'h00, OT, 1'b0, 1'b1);
    flt(6'h00, MC, 1'b1, 1'b1);
    flt(6'h00, BC, 1'b0, 1'b0);
    flt(6'h20, BC, 1'b1, 1'b1);
    flt(6'h04, ME, 1'b0, 1'b1);
    flt(6'h04, OT, 1'b0, 1'b0);
    flt(6'h04, MC, 1'b0, 1'b1);
    flt(6'h01, MC, 1'b1, 1'b0);
    flt(6'h01, MC, 1'b0, 1'b1);
    flt(6'h01, OT, 1'b1, 1'b1);
    flt(6'h10, MC, 1'b0, 1'b0);
    flt(6'h11, OT, 1'b1, 1'b1);
    flt(6'h03, OT, 1'b1, 1'b0);
    flt(6'h03, ME, 1'b0, 1'b1);
    flt(6'h13, MC, 1'b0, 1'b0);
    flt(6'h13, OT, 1'b0, 1'b1);
    flt(6'h08, MC, 1'b0, 1'b0);
    flt(6'h08, OT, 1'b0, 1'b0);
    $display("test filter done");
    tag1 = 16'h8100;
    csr_w(OFS_TAG_ONE, 32'h00008100);
    rxf(OT, 16'h8100, 10, 1'b0);
    rxf(OT, 16'h8100, 12, 1'b0);
    rxf(OT, 16'h0800, 8, 1'b0);
    rxf(OT, 16'h0000, 2, 1'b0);
    tag2 = 16'h88A8;
    csr_w(OFS_TAG_TWO, 32'h000088A8);
    rxf(OT, 16'h88A8, 12, 1'b0);
    rxf(OT, 16'h88A8, 30, 1'b0);
    $display("test tags done");
    split_set(8'h1F);
    rxf(MC, 16'h0800, 2, 1'b0);
    $display("test flush done");
    txr(1'b0);
    txr(1'b1);
    mem(1'b1, 24'hFFFFFF, 8'h5A, b);
    mem(1'b0, 24'hFFFFFF, 8'h00, b);
    check(b, 8'h5A);
    mem(1'b0, 24'h000010, 8'h00, b);
    check(b, 8'h00);
    $display("test memory done");
    final_report();
  end
endmodule : erf_rx_filter_tb_top
